//--- core/xfer_exec.sv
// Execution unit for store, code-read, stack, port and control instructions.
// How it works
// - Pre-decrement store: pointer minus one, then write source there, 2 cycles.
// - Post-increment store: write at pointer, then pointer plus one, 2 cycles.
// - Offset store writes at the selected pointer plus displacement, pointer kept, 2 cycles.
// - Direct store writes source to constant address in 2 cycles.
// - Code read loads byte at third pointer into r0 or named register, 3 cycles.
// - Push stores source register on the stack in 2 cycles.
// - Pop loads destination register from the stack in 2 cycles.
// - Sleep takes 1 cycle and signals the sleep function.
// - Watchdog restart takes 1 cycle and pulses the watchdog restart.
// No instruction here writes the status flags; the unit has no flag port at all.
module xfer_exec
  import xfer_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // Instruction issue
  input  wire logic              issue_valid_in,
  input  wire instr_t            issue_in,
  output logic                   issue_ready_out,
  // Register file and pointer pairs
  input  wire logic [DATA_W-1:0] src_data_in,
  input  wire logic [ADDR_W-1:0] ptr_first_in,
  input  wire logic [ADDR_W-1:0] ptr_second_in,
  input  wire logic [ADDR_W-1:0] ptr_third_in,
  input  wire logic [ADDR_W-1:0] stack_ptr_in,
  output reg_wr_t                reg_wr_out,
  output ptr_wr_t                ptr_wr_out,
  output logic [ADDR_W-1:0]      stack_ptr_out,
  // Data memory
  output mem_req_t               mem_req_out,
  input  wire logic [DATA_W-1:0] mem_rdata_in,
  // Program memory
  output logic                   code_rd_out,
  output logic [ADDR_W-1:0]      code_addr_out,
  input  wire logic [DATA_W-1:0] code_rdata_in,
  // I/O space
  output logic                   io_wr_out,
  output logic                   io_rd_out,
  output logic [IO_W-1:0]        io_addr_out,
  output logic [DATA_W-1:0]      io_wdata_out,
  input  wire logic [DATA_W-1:0] io_rdata_in,
  // Control
  output logic                   sleep_req_out,
  output logic                   wdog_restart_out,
  output logic                   done_out
);

  typedef enum logic [1:0] {
    EXEC_IDLE,
    EXEC_BUSY
  } state_t;

  state_t            state_ff;
  instr_t            instr_ff;
  logic [1:0]        cyc_ff;
  logic [1:0]        cyc_total;
  logic [ADDR_W-1:0] sel_ptr;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] new_ptr;
  logic              ptr_changes;
  logic              take;
  logic              last_cyc;

  // Pointer selection works from the latched instruction and serves only the busy phase.
  function automatic logic [ADDR_W-1:0] pick_ptr(input ptr_sel_t s,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [ADDR_W-1:0] b,
                                                 input logic [ADDR_W-1:0] c);
    if (s == PTR_FIRST) begin
      return a;
    end else if (s == PTR_SECOND) begin
      return b;
    end else begin
      return c;
    end
  endfunction

  function automatic logic [1:0] op_cycles(input op_t op);
    case (op)
      OP_POINTER_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE: return CYC_STORE;
      OP_PUSH, OP_POP:                                    return CYC_STACK;
      OP_CODE_READ:                                       return CYC_CODE;
      default:                                            return CYC_ONE;
    endcase
  endfunction

  assign issue_ready_out = (state_ff == EXEC_IDLE);
  assign take            = issue_valid_in && issue_ready_out;
  assign cyc_total       = op_cycles(instr_ff.op);
  assign last_cyc        = (state_ff == EXEC_BUSY) && (cyc_ff == cyc_total);

  // Code reads always go through the third pointer.
  always_comb begin
    if (instr_ff.op == OP_CODE_READ) begin
      sel_ptr = ptr_third_in;
    end else begin
      sel_ptr = pick_ptr(instr_ff.ptr, ptr_first_in, ptr_second_in, ptr_third_in);
    end
  end

  addr_gen #(
    .AW (ADDR_W)
  ) u_addr_gen (
    .ptr_in          (sel_ptr),
    .mode_in         ((instr_ff.op == OP_OFFSET_WRITE) ? MODE_PLAIN : instr_ff.mode),
    .disp_in         ((instr_ff.op == OP_OFFSET_WRITE) ? instr_ff.disp : '0),
    .eff_addr_out    (eff_addr),
    .new_ptr_out     (new_ptr),
    .ptr_changes_out (ptr_changes)
  );

  // Every instruction is latched, then retired after its cycle count.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= EXEC_IDLE;
      instr_ff <= '0;
      cyc_ff   <= '0;
    end else if (take) begin
      state_ff <= EXEC_BUSY;
      instr_ff <= issue_in;
      cyc_ff   <= CYC_ONE;
    end else if (last_cyc) begin
      state_ff <= EXEC_IDLE;
      cyc_ff   <= '0;
    end else if (state_ff == EXEC_BUSY) begin
      cyc_ff   <= cyc_ff + CYC_ONE;
    end
  end

  // Memory traffic is issued in the first busy cycle, data returns in the last.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_req_out   <= '0;
      code_rd_out   <= 1'b0;
      code_addr_out <= '0;
      io_wr_out     <= 1'b0;
      io_rd_out     <= 1'b0;
      io_addr_out   <= '0;
      io_wdata_out  <= '0;
    end else begin
      mem_req_out <= '0;
      code_rd_out <= 1'b0;
      io_wr_out   <= 1'b0;
      io_rd_out   <= 1'b0;
      if (take) begin
        case (issue_in.op)
          OP_PORT_OUT: begin
            io_wr_out    <= 1'b1;
            io_addr_out  <= issue_in.io_addr;
            io_wdata_out <= src_data_in;
          end
          OP_PORT_IN: begin
            io_rd_out   <= 1'b1;
            io_addr_out <= issue_in.io_addr;
          end
          default: begin
          end
        endcase
      end else if (state_ff == EXEC_BUSY && cyc_ff == CYC_ONE) begin
        case (instr_ff.op)
          OP_POINTER_WRITE, OP_OFFSET_WRITE: begin
            mem_req_out.wr    <= 1'b1;
            mem_req_out.addr  <= eff_addr;
            mem_req_out.wdata <= src_data_in;
          end
          OP_DIRECT_WRITE: begin
            mem_req_out.wr    <= 1'b1;
            mem_req_out.addr  <= instr_ff.k_addr;
            mem_req_out.wdata <= src_data_in;
          end
          OP_PUSH: begin
            mem_req_out.wr    <= 1'b1;
            mem_req_out.addr  <= stack_ptr_in;
            mem_req_out.wdata <= src_data_in;
          end
          OP_POP: begin
            mem_req_out.rd    <= 1'b1;
            mem_req_out.addr  <= stack_ptr_in + PTR_STEP;
          end
          OP_CODE_READ: begin
            code_rd_out   <= 1'b1;
            code_addr_out <= sel_ptr;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Register and pointer write-back happen once, on the retiring cycle.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_wr_out    <= '0;
      ptr_wr_out    <= '{we: 1'b0, sel: PTR_FIRST, value: '0};
      stack_ptr_out <= '0;
    end else begin
      reg_wr_out.we <= 1'b0;
      ptr_wr_out.we <= 1'b0;
      stack_ptr_out <= stack_ptr_in;
      if (last_cyc) begin
        case (instr_ff.op)
          OP_POINTER_WRITE: begin
            ptr_wr_out.we    <= ptr_changes;
            ptr_wr_out.sel   <= instr_ff.ptr;
            ptr_wr_out.value <= new_ptr;
          end
          OP_CODE_READ: begin
            reg_wr_out.we    <= 1'b1;
            reg_wr_out.idx   <= instr_ff.code_to_r0 ? REG_ZERO : instr_ff.reg_idx;
            reg_wr_out.data  <= code_rdata_in;
            ptr_wr_out.we    <= (instr_ff.mode == MODE_POST_INC);
            ptr_wr_out.sel   <= PTR_THIRD;
            ptr_wr_out.value <= sel_ptr + PTR_STEP;
          end
          OP_PUSH: begin
            stack_ptr_out <= stack_ptr_in - PTR_STEP;
          end
          OP_POP: begin
            reg_wr_out.we   <= 1'b1;
            reg_wr_out.idx  <= instr_ff.reg_idx;
            reg_wr_out.data <= mem_rdata_in;
            stack_ptr_out   <= stack_ptr_in + PTR_STEP;
          end
          OP_PORT_IN: begin
            reg_wr_out.we   <= 1'b1;
            reg_wr_out.idx  <= instr_ff.reg_idx;
            reg_wr_out.data <= io_rdata_in;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Sleep and watchdog are one-cycle pulses on retirement; nop does nothing.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sleep_req_out    <= 1'b0;
      wdog_restart_out <= 1'b0;
      done_out         <= 1'b0;
    end else begin
      sleep_req_out    <= last_cyc && (instr_ff.op == OP_SLEEP);
      wdog_restart_out <= last_cyc && (instr_ff.op == OP_WATCHDOG_RESTART);
      done_out         <= last_cyc;
    end
  end

  // Cycles since issue, for checking the latency of the store class.
  logic [2:0] age_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      age_ff <= '0;
    end else if (take) begin
      age_ff <= 3'h1;
    end else if (state_ff == EXEC_BUSY) begin
      age_ff <= age_ff + 3'h1;
    end
  end

  property p_store_len;
    @(posedge clk_in) disable iff (!rst_b_in)
      (last_cyc && instr_ff.op inside {OP_POINTER_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE})
      |-> (age_ff == 3'h2);
  endproperty
  a_store_len: assert property (p_store_len) else $error("store length wrong");

  property p_predec_addr;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_POINTER_WRITE && issue_in.mode == MODE_PRE_DEC)
      ##1 1'b1 |=> (mem_req_out.wr && mem_req_out.addr == $past(sel_ptr) - PTR_STEP);
  endproperty
  a_predec_addr: assert property (p_predec_addr) else $error("pre-dec address wrong");

  property p_postinc_ptr;
    @(posedge clk_in) disable iff (!rst_b_in)
      (last_cyc && instr_ff.op == OP_POINTER_WRITE && instr_ff.mode == MODE_POST_INC)
      |=> (ptr_wr_out.we && ptr_wr_out.value == $past(sel_ptr) + PTR_STEP);
  endproperty
  a_postinc_ptr: assert property (p_postinc_ptr) else $error("post-inc pointer wrong");

  property p_offset_keeps;
    @(posedge clk_in) disable iff (!rst_b_in)
      (last_cyc && instr_ff.op == OP_OFFSET_WRITE) |=> !ptr_wr_out.we;
  endproperty
  a_offset_keeps: assert property (p_offset_keeps) else $error("offset store moved pointer");

  property p_code_len;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_CODE_READ) |-> ##3 (last_cyc);
  endproperty
  a_code_len: assert property (p_code_len) else $error("code read not 3 cycles");

  property p_push_write;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_PUSH) |-> ##2 (mem_req_out.wr) ##1 (done_out);
  endproperty
  a_push_write: assert property (p_push_write) else $error("push not written");

  property p_pop_load;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_POP) |-> ##3 (reg_wr_out.we && done_out);
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("pop not loaded");

  property p_sleep_one;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_SLEEP) |-> ##2 (sleep_req_out && !mem_req_out.wr);
  endproperty
  a_sleep_one: assert property (p_sleep_one) else $error("sleep timing wrong");

  property p_wdog_one;
    @(posedge clk_in) disable iff (!rst_b_in)
      wdog_restart_out |=> !wdog_restart_out;
  endproperty
  a_wdog_one: assert property (p_wdog_one) else $error("watchdog pulse too long");

  property p_nop_quiet;
    @(posedge clk_in) disable iff (!rst_b_in)
      (take && issue_in.op == OP_NOP) |-> ##2 (!reg_wr_out.we && !ptr_wr_out.we);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop changed state");

  c_store:  cover property (@(posedge clk_in) take && issue_in.op == OP_POINTER_WRITE);
  c_code:   cover property (@(posedge clk_in) last_cyc && instr_ff.op == OP_CODE_READ);
  c_pop:    cover property (@(posedge clk_in) last_cyc && instr_ff.op == OP_POP);
  c_b2b:    cover property (@(posedge clk_in) last_cyc ##1 take);

endmodule

//--- core/xfer_exec_pkg.sv
// Shared constants and carrier types for the data-transfer execution unit.
package xfer_exec_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned REG_W   = 5;
  localparam int unsigned DISP_W  = 6;
  localparam int unsigned IO_W    = 6;

  // Cycle counts per instruction class.
  localparam logic [1:0] CYC_STORE = 2'h2;
  localparam logic [1:0] CYC_STACK = 2'h2;
  localparam logic [1:0] CYC_CODE  = 2'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;

  localparam logic [REG_W-1:0]  REG_ZERO = 5'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;

  // Pointer pair selection.
  typedef enum logic [1:0] {
    PTR_FIRST,
    PTR_SECOND,
    PTR_THIRD
  } ptr_sel_t;

  // Addressing flavour of an indirect access.
  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_POST_INC,
    MODE_PRE_DEC
  } ptr_mode_t;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_POINTER_WRITE,
    OP_OFFSET_WRITE,
    OP_DIRECT_WRITE,
    OP_CODE_READ,
    OP_PUSH,
    OP_POP,
    OP_SLEEP,
    OP_WATCHDOG_RESTART,
    OP_PORT_IN,
    OP_PORT_OUT
  } op_t;

  // One decoded instruction as handed over by the fetch stage.
  typedef struct packed {
    op_t                 op;
    ptr_sel_t            ptr;
    ptr_mode_t           mode;
    logic [REG_W-1:0]    reg_idx;
    logic [DISP_W-1:0]   disp;
    logic [ADDR_W-1:0]   k_addr;
    logic [IO_W-1:0]     io_addr;
    logic                code_to_r0;
  } instr_t;

  // Data memory request (also serves the stack).
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } mem_req_t;

  // Register file write port.
  typedef struct packed {
    logic                we;
    logic [REG_W-1:0]    idx;
    logic [DATA_W-1:0]   data;
  } reg_wr_t;

  // Pointer pair write-back.
  typedef struct packed {
    logic                we;
    ptr_sel_t            sel;
    logic [ADDR_W-1:0]   value;
  } ptr_wr_t;

endpackage

//--- core/addr_gen.sv
// Effective address and pointer update for indirect accesses.
module addr_gen
  import xfer_exec_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  // Pointer and mode
  input  wire logic [AW-1:0]     ptr_in,
  input  wire ptr_mode_t         mode_in,
  input  wire logic [DISP_W-1:0] disp_in,
  // Results
  output logic [AW-1:0]          eff_addr_out,
  output logic [AW-1:0]          new_ptr_out,
  output logic                   ptr_changes_out
);

  always_comb begin
    eff_addr_out    = ptr_in + AW'(disp_in);
    new_ptr_out     = ptr_in;
    ptr_changes_out = 1'b0;
    case (mode_in)
      MODE_PRE_DEC: begin
        // The access uses the already decremented pointer.
        eff_addr_out    = ptr_in - AW'(PTR_STEP);
        new_ptr_out     = ptr_in - AW'(PTR_STEP);
        ptr_changes_out = 1'b1;
      end
      MODE_POST_INC: begin
        eff_addr_out    = ptr_in;
        new_ptr_out     = ptr_in + AW'(PTR_STEP);
        ptr_changes_out = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule

//--- tb/xfer_exec_bench.sv
// Self-checking bench for the data-transfer execution unit.
module xfer_exec_bench import xfer_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk_in;
  logic                rst_b_in;
  logic                issue_valid_in;
  instr_t              issue_in;
  logic                issue_ready_out;
  logic [DATA_W-1:0]   src_data_in;
  logic [DATA_W-1:0]   mem_rdata_in;
  logic [DATA_W-1:0]   code_rdata_in;
  logic [DATA_W-1:0]   io_rdata_in;
  logic [ADDR_W-1:0]   ptr_first_in;
  logic [ADDR_W-1:0]   ptr_second_in;
  logic [ADDR_W-1:0]   ptr_third_in;
  logic [ADDR_W-1:0]   stack_ptr_in;
  logic [ADDR_W-1:0]   stack_ptr_out;
  logic [ADDR_W-1:0]   code_addr_out;
  reg_wr_t             reg_wr_out;
  ptr_wr_t             ptr_wr_out;
  mem_req_t            mem_req_out;
  logic                code_rd_out;
  logic                io_wr_out;
  logic                io_rd_out;
  logic                sleep_req_out;
  logic                wdog_restart_out;
  logic                done_out;
  logic [IO_W-1:0]     io_addr_out;
  logic [DATA_W-1:0]   io_wdata_out;
  int                  fails;
  int                  samples_checked;
  string               names [10] = '{"done", "mem wr", "mem rd", "reg we", "ptr we",
                                      "code rd", "io wr", "io rd", "sleep", "wdog"};

  xfer_exec DUT (
    .clk_in, .rst_b_in, .issue_valid_in, .issue_in, .issue_ready_out,
    .src_data_in, .ptr_first_in, .ptr_second_in, .ptr_third_in, .stack_ptr_in,
    .reg_wr_out, .ptr_wr_out, .stack_ptr_out, .mem_req_out, .mem_rdata_in,
    .code_rd_out, .code_addr_out, .code_rdata_in, .io_wr_out, .io_rd_out,
    .io_addr_out, .io_wdata_out, .io_rdata_in, .sleep_req_out, .wdog_restart_out,
    .done_out
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [ADDR_W-1:0] seen,
                       input logic [ADDR_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [ADDR_W-1:0] cyc(input op_t op);
    case (op)
      OP_POINTER_WRITE, OP_OFFSET_WRITE, OP_DIRECT_WRITE, OP_PUSH, OP_POP: return 16'h0002;
      OP_CODE_READ: return 16'h0003;
      default: return 16'h0001;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] ptrv(input ptr_sel_t s);
    return (s == PTR_FIRST) ? ptr_first_in : (s == PTR_SECOND) ? ptr_second_in : ptr_third_in;
  endfunction

  // Offset stores only reach the second and third pairs; code reads use the third.
  function automatic instr_t legal(input instr_t i);
    instr_t o;
    o = i;
    if (o.op == OP_OFFSET_WRITE) begin
      o.mode = MODE_PLAIN;
      if (o.ptr == PTR_FIRST) o.ptr = PTR_THIRD;
    end
    if (o.op == OP_CODE_READ) begin
      o.ptr = PTR_THIRD;
      if (o.mode == MODE_PRE_DEC) o.mode = MODE_POST_INC;
    end
    return o;
  endfunction

  function automatic instr_t rand_ins();
    instr_t i;
    i = instr_t'({$urandom, $urandom});
    i.op = op_t'($urandom_range(10));
    i.ptr = ptr_sel_t'($urandom_range(2));
    i.mode = ptr_mode_t'($urandom_range(2));
    return legal(i);
  endfunction

  task automatic set_ptrs(input logic [ADDR_W-1:0] a, b, c, s);
    @(posedge clk_in);
    ptr_first_in <= a;
    ptr_second_in <= b;
    ptr_third_in <= c;
    stack_ptr_in <= s;
  endtask

  // Junk offered while busy is an output transfer, so a wrongly taken one shows as an extra io_wr.
  task automatic run(input instr_t ins, input logic refuse);
    logic [ADDR_W-1:0] cnt [10];
    logic [ADDR_W-1:0] ecnt [10];
    logic [ADDR_W-1:0] p, n, k_done, ma, ca, sp_d, e_ma, e_pv, e_ri, e_rv, e_sp;
    logic [DATA_W-1:0] wd, iod;
    logic [IO_W-1:0]   ioa;
    logic [9:0]        ev;
    logic [31:0]       rnd;
    reg_wr_t           rw;
    ptr_wr_t           pw;
    instr_t            junk;
    logic              rdy_d, rdy0;
    cnt = '{default: '0};
    ecnt = '{default: '0};
    rnd = $urandom;
    junk = ins;
    junk.op = OP_PORT_OUT;
    @(posedge clk_in);
    issue_valid_in <= 1'b1;
    issue_in <= ins;
    src_data_in <= rnd[7:0];
    mem_rdata_in <= rnd[15:8];
    code_rdata_in <= rnd[23:16];
    io_rdata_in <= rnd[31:24];
    @(posedge clk_in);
    n = cyc(ins.op);
    issue_valid_in <= refuse;
    issue_in <= junk;
    p = ptrv(ins.ptr);
    ecnt[0] = 16'h0001;
    e_ri = 16'(ins.reg_idx);
    e_sp = stack_ptr_in;
    case (ins.op)
      OP_POINTER_WRITE: begin
        ecnt[1] = 16'h0001;
        e_ma = (ins.mode == MODE_PRE_DEC) ? p - 16'h0001 : p;
        ecnt[4] = 16'(ins.mode != MODE_PLAIN);
        e_pv = (ins.mode == MODE_PRE_DEC) ? p - 16'h0001 : p + 16'h0001;
      end
      OP_OFFSET_WRITE: begin
        ecnt[1] = 16'h0001;
        e_ma = p + 16'(ins.disp);
      end
      OP_DIRECT_WRITE: begin
        ecnt[1] = 16'h0001;
        e_ma = ins.k_addr;
      end
      OP_CODE_READ: begin
        ecnt[5] = 16'h0001;
        ecnt[3] = 16'h0001;
        e_ri = ins.code_to_r0 ? 16'h0000 : 16'(ins.reg_idx);
        e_rv = 16'(code_rdata_in);
        ecnt[4] = 16'(ins.mode == MODE_POST_INC);
        e_pv = p + 16'h0001;
      end
      OP_PUSH: begin
        ecnt[1] = 16'h0001;
        e_ma = stack_ptr_in;
        e_sp = stack_ptr_in - 16'h0001;
      end
      OP_POP: begin
        ecnt[2] = 16'h0001;
        ecnt[3] = 16'h0001;
        e_ma = stack_ptr_in + 16'h0001;
        e_rv = 16'(mem_rdata_in);
        e_sp = stack_ptr_in + 16'h0001;
      end
      OP_SLEEP: ecnt[8] = 16'h0001;
      OP_WATCHDOG_RESTART: ecnt[9] = 16'h0001;
      OP_PORT_OUT: ecnt[6] = 16'h0001;
      OP_PORT_IN: begin
        ecnt[7] = 16'h0001;
        ecnt[3] = 16'h0001;
        e_rv = 16'(io_rdata_in);
      end
      default: ;
    endcase
    for (int k = 0; k <= int'(n) + 3; k++) begin
      @(negedge clk_in);
      ev = {wdog_restart_out, sleep_req_out, io_rd_out, io_wr_out, code_rd_out,
            ptr_wr_out.we, reg_wr_out.we, mem_req_out.rd, mem_req_out.wr, done_out};
      for (int j = 0; j < 10; j++) if (ev[j] === 1'b1) cnt[j] = cnt[j] + 16'h0001;
      if (k == 0) rdy0 = issue_ready_out;
      if (ev[0] === 1'b1) begin
        k_done = 16'(k);
        sp_d = stack_ptr_out;
        rdy_d = issue_ready_out;
      end
      if (ev[1] === 1'b1 || ev[2] === 1'b1) ma = mem_req_out.addr;
      if (ev[1] === 1'b1) wd = mem_req_out.wdata;
      if (ev[3] === 1'b1) rw = reg_wr_out;
      if (ev[4] === 1'b1) pw = ptr_wr_out;
      if (ev[5] === 1'b1) ca = code_addr_out;
      if (ev[6] === 1'b1 || ev[7] === 1'b1) ioa = io_addr_out;
      if (ev[6] === 1'b1) iod = io_wdata_out;
      @(posedge clk_in);
      issue_valid_in <= refuse && (16'(k + 1) < n);
    end
    for (int j = 0; j < 10; j++) check(names[j], cnt[j], ecnt[j]);
    check("done cycle", k_done, n);
    check("busy ready", 16'(rdy0), 16'h0000);
    check("ready at retire", 16'(rdy_d), 16'h0001);
    if (ecnt[1] != 0 || ecnt[2] != 0) check("mem addr", ma, e_ma);
    if (ecnt[1] != 0) check("mem wdata", 16'(wd), 16'(src_data_in));
    if (ecnt[3] != 0) check("reg idx", 16'(rw.idx), e_ri);
    if (ecnt[3] != 0) check("reg data", 16'(rw.data), e_rv);
    if (ecnt[4] != 0) check("ptr sel", 16'(pw.sel), 16'(ins.ptr));
    if (ecnt[4] != 0) check("ptr value", pw.value, e_pv);
    if (ecnt[5] != 0) check("code addr", ca, p);
    if (ecnt[6] != 0 || ecnt[7] != 0) check("io addr", 16'(ioa), 16'(ins.io_addr));
    if (ecnt[6] != 0) check("io wdata", 16'(iod), 16'(src_data_in));
    if (ins.op == OP_PUSH || ins.op == OP_POP) check("stack ptr", sp_d, e_sp);
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    fails++;
    conclude();
  end

  initial begin
    instr_t ins;
    rst_b_in = 1'b0;
    issue_valid_in = 1'b0;
    issue_in = '0;
    {src_data_in, mem_rdata_in, code_rdata_in, io_rdata_in} = '0;
    {ptr_first_in, ptr_second_in, ptr_third_in, stack_ptr_in} = '0;
    void'($urandom(32'h26D1CFA9));
    repeat (3) @(posedge clk_in);
    check("reset ready", 16'(issue_ready_out), 16'h0001);
    check("reset done", 16'(done_out), 16'h0000);
    rst_b_in <= 1'b1;
    // Wrap-around pointers: pre-decrement from zero, post-increment from all ones.
    set_ptrs(16'h0000, 16'hFFFF, 16'hFFF0, 16'h0000);
    run(legal('{op: OP_POINTER_WRITE, ptr: PTR_FIRST, mode: MODE_PRE_DEC, default: '0}), 1'b1);
    run(legal('{op: OP_POINTER_WRITE, ptr: PTR_SECOND, mode: MODE_POST_INC, default: '0}), 1'b1);
    run(legal('{op: OP_OFFSET_WRITE, ptr: PTR_THIRD, mode: MODE_PLAIN, disp: 6'h3F,
                default: '0}), 1'b1);
    run(legal('{op: OP_POP, ptr: PTR_FIRST, mode: MODE_PLAIN, default: '0}), 1'b0);
    $display("test corners done");
    for (int o = 0; o <= 10; o++) begin
      for (int m = 0; m <= 2; m++) begin
        ins = rand_ins();
        ins.op = op_t'(o);
        ins.mode = ptr_mode_t'(m);
        ins.code_to_r0 = m[0];
        run(legal(ins), m[1]);
      end
    end
    $display("test sweep done");
    repeat (150) begin
      set_ptrs(16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom));
      run(rand_ins(), 1'($urandom));
    end
    $display("test random done");
    // Reset in mid-instruction must drop the pending store.
    @(posedge clk_in);
    issue_valid_in <= 1'b1;
    issue_in <= legal('{op: OP_DIRECT_WRITE, ptr: PTR_FIRST, mode: MODE_PLAIN, default: '0});
    @(posedge clk_in);
    issue_valid_in <= 1'b0;
    rst_b_in <= 1'b0;
    @(negedge clk_in);
    check("mid reset ready", 16'(issue_ready_out), 16'h0001);
    // One edge later the store would have issued its write had reset not dropped it.
    @(negedge clk_in);
    check("mid reset wr", 16'(mem_req_out.wr), 16'h0000);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    run(rand_ins(), 1'b1);
    $display("test mid reset done");
    conclude();
  end
endmodule
